/* src/hbp_bridge_ctrl.sv */
`include "hbp_params.svh"
module hbp_bridge_ctrl
  import hbp_pkg::*;
#(
  parameter int unsigned STEP_80  = `HBP_STEP_CYC(`HBP_F80_HZ),
  parameter int unsigned STEP_100 = `HBP_STEP_CYC(`HBP_F100_HZ),
  parameter int unsigned STEP_200 = `HBP_STEP_CYC(`HBP_F200_HZ),
  parameter int unsigned STEP_2K  = `HBP_STEP_CYC(`HBP_F2K_HZ)
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    logic_supply_ok_i,
  input  wire logic                    en_i,
  input  wire logic                    motor_supply_ok_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic      [`HBP_NUM_HB-1:0]  hs_on_o,
  output logic      [`HBP_NUM_HB-1:0]  ls_on_o,
  output logic                         irq_o
);
  localparam int          NHB   = `HBP_NUM_HB;
  localparam int          NCH   = `HBP_NUM_CH;
  localparam logic [6:0]  DEAD  = 7'(`HBP_DEAD_CYC);

  // ****************************************************
  // Pin synchronisers and mode
  // ****************************************************
  logic en_m_q, en_s_q;
  logic vdd_m_q, vdd_s_q;
  logic vs_m_q, vs_s_q, vs_old_q;
  logic run_q, run_old_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_m_q   <= 1'b0;
      en_s_q   <= 1'b0;
      vdd_m_q  <= 1'b0;
      vdd_s_q  <= 1'b0;
      vs_m_q   <= 1'b0;
      vs_s_q   <= 1'b0;
      vs_old_q <= 1'b0;
    end else begin
      en_m_q   <= en_i;
      en_s_q   <= en_m_q;
      vdd_m_q  <= logic_supply_ok_i;
      vdd_s_q  <= vdd_m_q;
      vs_m_q   <= motor_supply_ok_i;
      vs_s_q   <= vs_m_q;
      vs_old_q <= vs_s_q;
    end
  end

  // Normal mode only with enable high and the logic supply healthy;
  // anything else holds the whole register bank in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q     <= 1'b0;
      run_old_q <= 1'b0;
    end else begin
      run_q     <= en_s_q && vdd_s_q;
      run_old_q <= run_q;
    end
  end

  // ****************************************************
  // Wishbone slave
  // ****************************************************
  logic        acc;
  logic        wr;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] act_q, asg_q, fw_q, duty_q, freq_q;
  logic [31:0] ist_q, imsk_q;
  logic        power_on_flag_n_q;
  logic [`HBP_EV_W-1:0] ev;

  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] nw,
                                        logic [3:0]  sel,
                                        logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r & msk;
  endfunction : merge

  function automatic logic [31:0] bytes(logic [31:0] d,
                                        logic [3:0]  sel);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : bytes

  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  // A dead logic supply leaves the bus answering but deaf
  assign wr  = acc && wb_we_i && run_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= `HBP_RST_VAL;
    end else if (acc) begin
      case (wb_adr_i)
        `HBP_ADR_ACT:     rdat_q <= act_q;
        `HBP_ADR_ASSIGN:  rdat_q <= asg_q;
        `HBP_ADR_FW:      rdat_q <= fw_q;
        `HBP_ADR_DUTY:    rdat_q <= duty_q;
        `HBP_ADR_FREQ:    rdat_q <= freq_q;
        `HBP_ADR_FLAG:    rdat_q <= {31'h0, power_on_flag_n_q};
        `HBP_ADR_IRQ_ST:  rdat_q <= ist_q;
        `HBP_ADR_IRQ_MSK: rdat_q <= imsk_q;
        default:          rdat_q <= `HBP_RST_VAL;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************************
  // Control registers
  // ****************************************************
  // Sleep and undervoltage clear every bank; a motor supply dropout
  // does not touch them so the drive resumes by itself
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q) begin
      act_q  <= `HBP_RST_VAL;
      asg_q  <= `HBP_RST_VAL;
      fw_q   <= `HBP_RST_VAL;
      duty_q <= `HBP_RST_VAL;
      freq_q <= `HBP_RST_VAL;
      imsk_q <= `HBP_RST_VAL;
    end else if (wr) begin
      case (wb_adr_i)
        `HBP_ADR_ACT:
          act_q  <= merge(act_q, wb_dat_i, wb_sel_i, `HBP_MSK_ACT);
        `HBP_ADR_ASSIGN:
          asg_q  <= merge(asg_q, wb_dat_i, wb_sel_i, `HBP_MSK_ASSIGN);
        `HBP_ADR_FW:
          fw_q   <= merge(fw_q, wb_dat_i, wb_sel_i, `HBP_MSK_FW);
        `HBP_ADR_DUTY:
          duty_q <= merge(duty_q, wb_dat_i, wb_sel_i, `HBP_MSK_DUTY);
        `HBP_ADR_FREQ:
          freq_q <= merge(freq_q, wb_dat_i, wb_sel_i, `HBP_MSK_FREQ);
        `HBP_ADR_IRQ_MSK:
          imsk_q <= merge(imsk_q, wb_dat_i, wb_sel_i, `HBP_MSK_IRQ);
        default: ;
      endcase
    end
  end

  // Flag reads zero after any reset until software writes a one
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q) begin
      power_on_flag_n_q <= 1'b0;
    end else if (wr && wb_adr_i == `HBP_ADR_FLAG && wb_sel_i[0]
                 && wb_dat_i[0]) begin
      power_on_flag_n_q <= 1'b1;
    end
  end

  // ****************************************************
  // PWM channels
  // ****************************************************
  logic [NCH-1:0] ch_pwm;
  logic [NCH-1:0] ch_run;
  logic [NCH-1:0] ch_start;

  hbp_chan_if chi [NCH] ();

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign chi[g].freq  = hbp_freq_t'(freq_q[2*g +: 2]);
    assign chi[g].fast  = freq_q[`HBP_FAST_LSB + g];
    assign chi[g].duty  = duty_q[8*g +: 8];
    assign ch_pwm[g]    = chi[g].pwm;
    assign ch_run[g]    = chi[g].run;
    assign ch_start[g]  = chi[g].start;

    hbp_pwm_chan #(
      .STEP_80  (STEP_80),
      .STEP_100 (STEP_100),
      .STEP_200 (STEP_200),
      .STEP_2K  (STEP_2K)
    ) u_chan (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .clr_i (!run_q),
      .ch    (chi[g])
    );
  end

  // ****************************************************
  // Interrupts
  // ****************************************************
  assign ev[`HBP_EV_RESET] = run_q && !run_old_q;
  assign ev[`HBP_EV_PER_LSB +: NCH] = ch_start;
  assign ev[`HBP_EV_MOTOR] = vs_old_q && !vs_s_q;

  // A new event in the clearing cycle survives the write-one-clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q) begin
      ist_q <= `HBP_RST_VAL;
    end else if (wr && wb_adr_i == `HBP_ADR_IRQ_ST) begin
      ist_q <= ((ist_q & ~bytes(wb_dat_i, wb_sel_i))
               | 32'(ev)) & `HBP_MSK_IRQ;
    end else begin
      ist_q <= (ist_q | 32'(ev)) & `HBP_MSK_IRQ;
    end
  end

  assign irq_o = |(ist_q & imsk_q);

  // ****************************************************
  // Bridge drive
  // ****************************************************
  logic [NHB-1:0] hs_req;
  logic [NHB-1:0] ls_req;
  logic           gate;

  assign gate = run_q && vs_s_q;

  always_comb begin
    logic [1:0] sel;
    logic       on;
    logic       hs_a;
    logic       ls_a;
    sel  = 2'h0;
    on   = 1'b0;
    hs_a = 1'b0;
    ls_a = 1'b0;
    for (int b = 0; b < NHB; b++) begin
      sel  = asg_q[2*b +: 2];
      hs_a = act_q[b];
      ls_a = act_q[`HBP_ACT_LS_LSB + b];
      hs_req[b] = 1'b0;
      ls_req[b] = 1'b0;
      if (sel == 2'h0) begin
        hs_req[b] = hs_a;
        ls_req[b] = ls_a;
      end else begin
        on = ch_run[sel - 2'h1] && ch_pwm[sel - 2'h1];
        if (hs_a) begin
          hs_req[b] = on;
          ls_req[b] = fw_q[b] && !on;
        end else if (ls_a) begin
          ls_req[b] = on;
          hs_req[b] = fw_q[b] && !on;
        end
      end
    end
  end

  hbp_drv_t       drv_q  [NHB];
  logic [6:0]     dead_q [NHB];

  // Conflicting requests park the bridge off; every change of side
  // passes through a dead interval with both switches open
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < NHB; b++) begin
      if (rst_i || !gate) begin
        drv_q[b]  <= HBP_DRV_OFF;
        dead_q[b] <= DEAD;
      end else begin
        case (drv_q[b])
          HBP_DRV_OFF: begin
            if (dead_q[b] != 7'h0) begin
              dead_q[b] <= dead_q[b] - 7'h1;
            end else if (hs_req[b] && !ls_req[b]) begin
              drv_q[b] <= HBP_DRV_HS;
            end else if (ls_req[b] && !hs_req[b]) begin
              drv_q[b] <= HBP_DRV_LS;
            end
          end
          HBP_DRV_HS: begin
            if (!hs_req[b] || ls_req[b]) begin
              drv_q[b]  <= HBP_DRV_OFF;
              dead_q[b] <= DEAD;
            end
          end
          HBP_DRV_LS: begin
            if (!ls_req[b] || hs_req[b]) begin
              drv_q[b]  <= HBP_DRV_OFF;
              dead_q[b] <= DEAD;
            end
          end
          default: begin
            drv_q[b]  <= HBP_DRV_OFF;
            dead_q[b] <= DEAD;
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int b = 0; b < NHB; b++) begin
      hs_on_o[b] = (drv_q[b] == HBP_DRV_HS);
      ls_on_o[b] = (drv_q[b] == HBP_DRV_LS);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_no_shoot;
    (hs_on_o & ls_on_o) == '0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both switches of a bridge on");

  sequence s_hs_released;
    $fell(hs_on_o[0]);
  endsequence
  property p_dead_gap;
    s_hs_released |-> !ls_on_o[0] [*8];
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("low side on without dead interval");

  property p_sleep_off;
    !run_q |=> (hs_on_o == '0) && (ls_on_o == '0);
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("switch on in sleep");

  property p_sleep_clear;
    !run_q |=> (act_q == '0) && (freq_q == '0) && (asg_q == '0);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear)
    else $error("registers kept through sleep");

  property p_flag_low;
    $rose(run_q) |-> !power_on_flag_n_q ##1 !power_on_flag_n_q;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("power-on flag not zero after reset");

  property p_keep_cfg;
    (run_q && !vs_s_q && !wr) |=> $stable(act_q) && $stable(duty_q);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg)
    else $error("motor supply loss changed configuration");

  property p_fw_stop;
    (act_q[2] && asg_q[5:4] != 2'h0 && fw_q[2]
     && !ch_run[asg_q[5:4] - 2'h1]) |-> !hs_req[2] && ls_req[2];
  endproperty
  a_fw_stop: assert property (p_fw_stop)
    else $error("free-wheel with stopped channel wrong");

  property p_cont;
    (asg_q[1:0] == 2'h0 && act_q[0] && !act_q[`HBP_ACT_LS_LSB])
      |-> hs_req[0] && !ls_req[0];
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous drive not requested");

  property p_irq;
    (run_q && vs_old_q && !vs_s_q) |=> ist_q[`HBP_EV_MOTOR];
  endproperty
  a_irq: assert property (p_irq)
    else $error("motor supply dropout not reported");
endmodule : hbp_bridge_ctrl

/* src/hbp_params.svh */
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// ****************************************************
// Timing
// ****************************************************
`define HBP_CLK_HZ      125000000
`define HBP_DEAD_NS     500
`define HBP_DEAD_CYC    ((`HBP_DEAD_NS * (`HBP_CLK_HZ / 1000000) + 999) / 1000)
`define HBP_F80_HZ      80
`define HBP_F100_HZ     100
`define HBP_F200_HZ     200
`define HBP_F2K_HZ      2000
`define HBP_DUTY_STEPS  256
`define HBP_STEP_CYC(f) (`HBP_CLK_HZ / ((f) * `HBP_DUTY_STEPS))

// ****************************************************
// Register map and fields
// ****************************************************
`define HBP_NUM_HB      12
`define HBP_NUM_CH      3
`define HBP_ADR_ACT     8'h00
`define HBP_ADR_ASSIGN  8'h04
`define HBP_ADR_FW      8'h08
`define HBP_ADR_DUTY    8'h0C
`define HBP_ADR_FREQ    8'h10
`define HBP_ADR_FLAG    8'h14
`define HBP_ADR_IRQ_ST  8'h18
`define HBP_ADR_IRQ_MSK 8'h1C
`define HBP_MSK_ACT     32'h0FFF0FFF
`define HBP_MSK_ASSIGN  32'h00FFFFFF
`define HBP_MSK_FW      32'h00000FFF
`define HBP_MSK_DUTY    32'h00FFFFFF
`define HBP_MSK_FREQ    32'h0000073F
`define HBP_MSK_IRQ     32'h0000001F
`define HBP_RST_VAL     32'h00000000
`define HBP_ACT_LS_LSB  16
`define HBP_FAST_LSB    8
`define HBP_EV_RESET    0
`define HBP_EV_PER_LSB  1
`define HBP_EV_MOTOR    4
`define HBP_EV_W        5
`endif

/* src/hbp_pkg.sv */
package hbp_pkg;
  typedef enum logic [1:0] {
    HBP_FREQ_OFF  = 2'h0,
    HBP_FREQ_80   = 2'h1,
    HBP_FREQ_100  = 2'h2,
    HBP_FREQ_200  = 2'h3
  } hbp_freq_t;
  typedef enum logic [2:0] {
    HBP_DRV_OFF = 3'b001,
    HBP_DRV_HS  = 3'b010,
    HBP_DRV_LS  = 3'b100
  } hbp_drv_t;
endpackage : hbp_pkg

/* src/hbp_chan_if.sv */
interface hbp_chan_if;
  import hbp_pkg::*;
  hbp_freq_t  freq;
  logic       fast;
  logic [7:0] duty;
  logic       pwm;
  logic       run;
  logic       start;
  modport ctrl (output freq, output fast, output duty,
                input pwm, input run, input start);
  modport chan (input freq, input fast, input duty,
                output pwm, output run, output start);
endinterface : hbp_chan_if

/* src/hbp_pwm_chan.sv */
`include "hbp_params.svh"
module hbp_pwm_chan
  import hbp_pkg::*;
#(
  parameter int unsigned STEP_80  = `HBP_STEP_CYC(`HBP_F80_HZ),
  parameter int unsigned STEP_100 = `HBP_STEP_CYC(`HBP_F100_HZ),
  parameter int unsigned STEP_200 = `HBP_STEP_CYC(`HBP_F200_HZ),
  parameter int unsigned STEP_2K  = `HBP_STEP_CYC(`HBP_F2K_HZ)
) (
  input wire logic  clk_i,
  input wire logic  rst_i,
  input wire logic  clr_i,
  hbp_chan_if.chan  ch
);
  hbp_freq_t   freq_q;
  logic        fast_q;
  logic [7:0]  duty_q;
  logic [7:0]  pos_q;
  logic [31:0] pre_q;
  logic        running;
  logic        pre_end;
  logic        bound;

  function automatic logic [31:0] step_len(hbp_freq_t f, logic fast);
    logic [31:0] n;
    n = 32'(STEP_80);
    if (fast) begin
      n = 32'(STEP_2K);
    end else if (f == HBP_FREQ_100) begin
      n = 32'(STEP_100);
    end else if (f == HBP_FREQ_200) begin
      n = 32'(STEP_200);
    end
    return n;
  endfunction : step_len

  assign running = (freq_q != HBP_FREQ_OFF);
  assign pre_end = (pre_q >= step_len(freq_q, fast_q) - 32'h1);
  assign bound   = running && pre_end && (pos_q == 8'hFF);

  // Shadow values load only while stopped or at the period end, so a
  // running waveform never sees a half-updated setting
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      freq_q <= HBP_FREQ_OFF;
      fast_q <= 1'b0;
      duty_q <= 8'h00;
      pre_q  <= 32'h0;
      pos_q  <= 8'h00;
    end else if (!running || bound) begin
      freq_q <= ch.freq;
      fast_q <= ch.fast;
      duty_q <= ch.duty;
      pre_q  <= 32'h0;
      pos_q  <= 8'h00;
    end else if (pre_end) begin
      pre_q  <= 32'h0;
      pos_q  <= pos_q + 8'h01;
    end else begin
      pre_q  <= pre_q + 32'h1;
    end
  end

  assign ch.pwm   = running && (pos_q < duty_q);
  assign ch.run   = running;
  assign ch.start = bound;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_stop_off;
    (!running && ch.freq == HBP_FREQ_OFF) |=> !ch.pwm && !ch.start;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("stopped channel drives pwm");

  property p_hold_duty;
    (running && !bound && !clr_i) |=> $stable(duty_q) && $stable(freq_q);
  endproperty
  a_hold_duty: assert property (p_hold_duty)
    else $error("pwm setting changed inside a period");
endmodule : hbp_pwm_chan

/* sim/hbp_host_model.sv */
module hbp_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // ****************************************************
  // One classic cycle, held until ack is sampled high
  // ****************************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    sel_o <= 4'h0;
    // Released lines must not keep showing the last value
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : hbp_host_model

/* sim/tb_half_bridge_pwm_control.sv */
`include "hbp_params.svh"
module tb_half_bridge_pwm_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S80  = 4;
  localparam int S100 = 3;
  localparam int S200 = 2;
  localparam int S2K  = 1;
  localparam logic [7:0]  RA [4] = '{`HBP_ADR_ASSIGN, `HBP_ADR_FW,
                                     `HBP_ADR_DUTY, `HBP_ADR_IRQ_MSK};
  localparam logic [31:0] RM [4] = '{`HBP_MSK_ASSIGN, `HBP_MSK_FW,
                                     `HBP_MSK_DUTY, `HBP_MSK_IRQ};
  localparam logic [31:0] FQ [4] = '{32'h1, 32'h2, 32'h3, 32'h103};
  localparam int PER [4] = '{256*S80, 256*S100, 256*S200, 256*S2K};
  logic        clk_i, rst_i, sup_ok, en, mot_ok;
  logic        cyc, stb, we, ack, irq, fw_seen;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, d;
  logic [11:0] hs, ls;
  logic [31:0] exp_q [$];
  int          failures, total_checks, n;
  int          seed = 32'h9B387D88;

  hbp_bridge_ctrl #(.STEP_80(S80), .STEP_100(S100), .STEP_200(S200),
    .STEP_2K(S2K)) u_hbp_bridge_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .logic_supply_ok_i(sup_ok), .en_i(en),
    .motor_supply_ok_i(mot_ok), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .hs_on_o(hs), .ls_on_o(ls),
    .irq_o(irq));
  hbp_host_model u_hbp_host_model (.clk_i(clk_i), .ack_i(ack),
    .dat_i(dat_r), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(dat_w));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    u_hbp_host_model.xfer(1'b1, a, v, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    u_hbp_host_model.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic cycles(input int c);
    repeat (c) @(posedge clk_i);
  endtask : cycles
  // Counts cycles up to the next rising edge of bridge 2 high side
  task automatic rise(output int c);
    logic p;
    c = 0;
    do begin
      p = hs[2];
      @(posedge clk_i);
      c++;
      fw_seen = fw_seen | (ls[2] === 1'b1);
    end while (!(hs[2] === 1'b1 && p !== 1'b1) && c < 5000);
  endtask : rise

  // ****************************************************
  // Output monitors
  // ****************************************************
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(dat_r, exp_q.pop_front());
    end
    if (rst_i === 1'b0) check(32'(hs & ls), 32'h0);
  end

  initial begin
    #(60000 * 8);
    failures++;
    final_report();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_i = 1'b1;
    sup_ok = 1'b1;
    en = 1'b1;
    mot_ok = 1'b1;
    fw_seen = 1'b0;
    cycles(4);
    rst_i <= 1'b0;
    cycles(8);
    check(32'({hs, ls, ack}), 32'h0);
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), (a == `HBP_ADR_IRQ_ST) ? 32'h1 : 32'h0);
    end
    check(32'(irq), 32'h0);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(RA[i], d);
      rd(RA[i], d & RM[i]);
    end
    $display("Test field masks done");
    for (int k = 0; k < 2; k++) begin
      wr(`HBP_ADR_FLAG, 32'h1);
      rd(`HBP_ADR_FLAG, 32'h1);
      wr(`HBP_ADR_ASSIGN, 32'h0);
      wr(`HBP_ADR_ACT, 32'h0FFF_0000);
      cycles(70);
      check(32'({hs, ls}), 32'h000_FFF);
      if (k == 0) en <= 1'b0;
      else sup_ok <= 1'b0;
      cycles(6);
      check(32'(hs | ls), 32'h0);
      wr(`HBP_ADR_ACT, 32'h1);
      en <= 1'b1;
      sup_ok <= 1'b1;
      cycles(6);
      rd(`HBP_ADR_ACT, 32'h0);
      rd(`HBP_ADR_ASSIGN, 32'h0);
      rd(`HBP_ADR_FLAG, 32'h0);
    end
    $display("Test sleep and undervoltage done");
    wr(`HBP_ADR_ACT, 32'h0002_0001);
    cycles(20);
    check(32'(hs | ls), 32'h0);
    cycles(60);
    check(32'({hs, ls}), 32'h001_002);
    wr(`HBP_ADR_ACT, 32'h0003_0000);
    cycles(20);
    check(32'({hs, ls}), 32'h000_002);
    cycles(60);
    check(32'({hs, ls}), 32'h000_003);
    $display("Test continuous drive done");
    wr(`HBP_ADR_IRQ_MSK, 32'h10);
    check(32'(irq), 32'h0);
    mot_ok <= 1'b0;
    cycles(6);
    check(32'({hs, ls, irq}), 32'h1);
    mot_ok <= 1'b1;
    cycles(80);
    check(32'({hs, ls}), 32'h000_003);
    rd(`HBP_ADR_ACT, 32'h0003_0000);
    wr(`HBP_ADR_IRQ_ST, 32'h10);
    cycles(2);
    check(32'(irq), 32'h0);
    wr(`HBP_ADR_ACT, 32'h0);
    $display("Test motor supply and interrupt done");
    wr(`HBP_ADR_FREQ, 32'h0);
    wr(`HBP_ADR_ASSIGN, 32'h10);
    wr(`HBP_ADR_DUTY, 32'h80);
    wr(`HBP_ADR_FW, 32'h4);
    wr(`HBP_ADR_ACT, 32'h4);
    cycles(80);
    check(32'({hs[2], ls[2]}), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`HBP_ADR_FREQ, FQ[i]);
      rise(n);
      fw_seen = 1'b0;
      rise(n);
      check(32'(n), 32'(PER[i]));
      check(32'(fw_seen), 32'h1);
    end
    wr(`HBP_ADR_FREQ, 32'h0);
    cycles(600);
    check(32'({hs[2], ls[2]}), 32'h1);
    $display("Test PWM channel done");
    final_report();
  end
endmodule : tb_half_bridge_pwm_control
